/* File: src/uhirq_pkg.sv */
// uhirq_pkg: offsets, field positions, reset values and carriers for the
// host controller event, list pointer and frame timing register bank.
// assumes a 32-bit word register port addressed by byte address.
package uhirq_pkg;
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned DATA_W = 32;

   // =====================================================================
   // register byte addresses
   localparam logic [31:0] OFS_EVENT_STATUS  = 32'hB000_700C;
   localparam logic [31:0] OFS_ENABLE_SET    = 32'hB000_7010;
   localparam logic [31:0] OFS_ENABLE_CLEAR  = 32'hB000_7014;
   localparam logic [31:0] OFS_SHARED_AREA   = 32'hB000_7018;
   localparam logic [31:0] OFS_PERIODIC_CUR  = 32'hB000_701C;
   localparam logic [31:0] OFS_CONTROL_HEAD  = 32'hB000_7020;
   localparam logic [31:0] OFS_CONTROL_CUR   = 32'hB000_7024;
   localparam logic [31:0] OFS_BULK_HEAD     = 32'hB000_7028;
   localparam logic [31:0] OFS_BULK_CUR      = 32'hB000_702C;
   localparam logic [31:0] OFS_DONE_HEAD     = 32'hB000_7030;
   localparam logic [31:0] OFS_FRAME_LENGTH  = 32'hB000_7034;
   localparam logic [31:0] OFS_TIME_LEFT     = 32'hB000_7038;
   localparam logic [31:0] OFS_FRAME_NUMBER  = 32'hB000_703C;

   // =====================================================================
   // event bit positions and masks
   localparam int unsigned BIT_MASTER      = 31;
   localparam int unsigned BIT_OWNER       = 30;
   localparam int unsigned BIT_HUB         = 6;
   localparam int unsigned BIT_FRAME_OVF   = 5;
   localparam int unsigned BIT_FATAL       = 4;
   localparam int unsigned BIT_RESUME      = 3;
   localparam int unsigned BIT_SOF         = 2;
   localparam int unsigned BIT_DONE        = 1;
   localparam int unsigned BIT_OVERRUN     = 0;
   localparam logic [31:0] EVENT_MASK      = 32'h4000_006F;
   localparam logic [31:0] AREA_MASK       = 32'hFFFF_FF80;
   localparam logic [31:0] DESC_MASK       = 32'hFFFF_FFF0;
   localparam logic [31:0] FRAME_CFG_MASK  = 32'hFFFF_3FFF;
   localparam logic [31:0] FRAME_CFG_RESET = 32'h0000_2EDF;
   localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

   // =====================================================================
   // frame timing fields
   localparam int unsigned FRAME_W        = 14;
   localparam int unsigned PKT_W          = 15;
   localparam int unsigned PKT_LSB        = 16;
   localparam int unsigned TOGGLE_BIT     = 31;
   localparam int unsigned FNUM_W         = 16;
   localparam int unsigned FNUM_TOP       = 15;
   localparam int unsigned CLK_MHZ        = 100;
   localparam int unsigned BIT_RATE_MHZ   = 12;
   localparam int unsigned BIT_DIV_TENTHS = CLK_MHZ * 10 / BIT_RATE_MHZ;

   // =====================================================================
   // carriers
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } uhirq_req_t;

   typedef struct packed {
      logic hub_change;
      logic resume;
      logic done_written;
      logic overrun;
   } uhirq_evt_t;
endpackage

/* File: src/uhirq_regs.sv */
// uhirq_regs: event status, interrupt mask, descriptor pointers and frame
// timing for a full-speed host controller.
// assumes one 100 MHz clock; event inputs are same-clock one-cycle pulses;
// the list processor writes pointers through the hw_* write ports.
//
// Operation
// - ownership request from command register sets the owner change flag
// - root hub status change pulse sets hub change flag
// - each change of frame counter bit 15 sets overflow flag
// - fatal error flag and its enable bits read zero, writes ignored
// - resume detected on a downstream port sets resume flag
// - each start of frame sets the frame start flag
// - done list written flag set after done head written back
// - list processor overrun report sets the overrun flag
// - writing one to master enable turns on interrupt delivery
// - one to an enable bit enables that source, zero leaves it
// - writing one to master disable blocks all interrupt delivery
// - one to a disable bit disables that source, zero leaves it
// - shared area base keeps bits 31..7, low bits read zero
// - periodic current pointer keeps bits 31..4
// - control head and current pointers keep bits 31..4
// - bulk head and current pointers keep bits 31..4
// - completed head pointer keeps bits 31..4, low bits zero
// - at each frame start largest packet field loads the packet counter
// - frame length holds bit times minus one, default 11999
// - time left counts down at 12 MHz when running, reloads at zero
// - on reload time left toggle copies frame length toggle
// - 16-bit frame counter increments on each reload, wrapping
`default_nettype none
module uhirq_regs
   import uhirq_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   output logic      [DATA_W-1:0] rdata_o,
   input  wire logic              owner_change_request_i,
   input  wire logic              hub_change_i,
   input  wire logic              resume_i,
   input  wire logic              done_written_i,
   input  wire logic              overrun_i,
   input  wire logic              operational_i,
   input  wire logic              hw_periodic_we_i,
   input  wire logic              hw_control_we_i,
   input  wire logic              hw_bulk_we_i,
   input  wire logic              hw_done_we_i,
   input  wire logic [DATA_W-1:0] hw_pointer_i,
   output logic                   irq_o,
   output logic                   frame_start_o,
   output logic      [PKT_W-1:0]  largest_packet_bits_o,
   output logic      [FNUM_W-1:0] frame_counter_o
);
   // ======================================================================
   // reset release
   logic rst_meta;
   logic rst_sync;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // ======================================================================
   // decode
   uhirq_req_t req;
   assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

   function automatic logic wr_hit(uhirq_req_t r, logic [31:0] ofs);
      return r.wr && (r.addr == ofs);
   endfunction

   // ======================================================================
   // state
   logic [31:0]        status;
   logic [31:0]        mask;
   logic [31:0]        area;
   logic [31:0]        periodic_cur;
   logic [31:0]        control_head;
   logic [31:0]        control_cur;
   logic [31:0]        bulk_head;
   logic [31:0]        bulk_cur;
   logic [31:0]        done_head;
   logic [31:0]        frame_cfg;
   logic [FRAME_W-1:0] time_left;
   logic               time_toggle;
   logic [FNUM_W-1:0]  fnum;
   logic [7:0]         div_acc;
   logic               run_d;
   logic [PKT_W-1:0]   pkt_cnt;
   logic               sof;
   logic               irq;
   logic [31:0]        rdata;

   logic [31:0]        next_status;
   logic [31:0]        next_mask;
   logic [31:0]        next_area;
   logic [31:0]        next_periodic_cur;
   logic [31:0]        next_control_head;
   logic [31:0]        next_control_cur;
   logic [31:0]        next_bulk_head;
   logic [31:0]        next_bulk_cur;
   logic [31:0]        next_done_head;
   logic [31:0]        next_frame_cfg;
   logic [FRAME_W-1:0] next_time_left;
   logic               next_time_toggle;
   logic [FNUM_W-1:0]  next_fnum;
   logic [7:0]         next_div_acc;
   logic [PKT_W-1:0]   next_pkt_cnt;
   logic               next_sof;
   logic               next_irq;
   logic [31:0]        next_rdata;

   // ======================================================================
   // frame timing
   localparam logic [7:0] DIV_STEP = 8'h0A;
   logic tick;
   logic reload;
   logic [31:0] set_evt;
   always_comb begin
      next_div_acc = div_acc;
      tick = 1'b0;
      if (operational_i) begin
         if (div_acc + DIV_STEP >= 8'(BIT_DIV_TENTHS)) begin
            next_div_acc = 8'(div_acc + DIV_STEP - 8'(BIT_DIV_TENTHS));
            tick = 1'b1;
         end else begin
            next_div_acc = 8'(div_acc + DIV_STEP);
         end
      end else begin
         next_div_acc = 8'h00;
      end
      reload = operational_i && ((!run_d) || (tick && time_left == '0));
      next_time_left = time_left;
      next_time_toggle = time_toggle;
      next_fnum = fnum;
      next_pkt_cnt = pkt_cnt;
      if (reload) begin
         next_time_left = frame_cfg[FRAME_W-1:0];
         next_time_toggle = frame_cfg[TOGGLE_BIT];
         next_fnum = FNUM_W'(fnum + 1'b1);
         next_pkt_cnt = frame_cfg[PKT_LSB +: PKT_W];
      end else if (tick) begin
         next_time_left = FRAME_W'(time_left - 1'b1);
      end
      next_sof = reload;
   end

   // ======================================================================
   // events and mask
   localparam logic [31:0] MASK_BITS = EVENT_MASK | (32'h1 << BIT_MASTER);
   always_comb begin
      set_evt = ZERO_WORD;
      set_evt[BIT_OWNER] = owner_change_request_i;
      set_evt[BIT_HUB] = hub_change_i;
      set_evt[BIT_FRAME_OVF] = next_fnum[FNUM_TOP] ^ fnum[FNUM_TOP];
      set_evt[BIT_RESUME] = resume_i;
      set_evt[BIT_SOF] = sof;
      set_evt[BIT_DONE] = done_written_i;
      set_evt[BIT_OVERRUN] = overrun_i;
      next_status = status;
      if (wr_hit(req, OFS_EVENT_STATUS)) begin
         next_status = status & ~req.wdata;
      end
      next_status = (next_status | set_evt) & EVENT_MASK;
      next_mask = mask;
      if (wr_hit(req, OFS_ENABLE_SET)) begin
         next_mask = mask | (req.wdata & MASK_BITS);
      end
      if (wr_hit(req, OFS_ENABLE_CLEAR)) begin
         next_mask = mask & ~(req.wdata & MASK_BITS);
      end
      next_irq = next_mask[BIT_MASTER]
                 && |(next_status & next_mask & EVENT_MASK);
   end

   // ======================================================================
   // pointers
   always_comb begin
      next_area = area;
      next_periodic_cur = periodic_cur;
      next_control_head = control_head;
      next_control_cur = control_cur;
      next_bulk_head = bulk_head;
      next_bulk_cur = bulk_cur;
      next_done_head = done_head;
      next_frame_cfg = frame_cfg;
      if (wr_hit(req, OFS_SHARED_AREA)) begin
         next_area = req.wdata & AREA_MASK;
      end
      if (wr_hit(req, OFS_PERIODIC_CUR)) begin
         next_periodic_cur = req.wdata & DESC_MASK;
      end
      if (hw_periodic_we_i) begin
         next_periodic_cur = hw_pointer_i & DESC_MASK;
      end
      if (wr_hit(req, OFS_CONTROL_HEAD)) begin
         next_control_head = req.wdata & DESC_MASK;
      end
      if (wr_hit(req, OFS_CONTROL_CUR)) begin
         next_control_cur = req.wdata & DESC_MASK;
      end
      if (hw_control_we_i) begin
         next_control_cur = hw_pointer_i & DESC_MASK;
      end
      if (wr_hit(req, OFS_BULK_HEAD)) begin
         next_bulk_head = req.wdata & DESC_MASK;
      end
      if (wr_hit(req, OFS_BULK_CUR)) begin
         next_bulk_cur = req.wdata & DESC_MASK;
      end
      if (hw_bulk_we_i) begin
         next_bulk_cur = hw_pointer_i & DESC_MASK;
      end
      if (wr_hit(req, OFS_DONE_HEAD)) begin
         next_done_head = req.wdata & DESC_MASK;
      end
      if (hw_done_we_i) begin
         next_done_head = hw_pointer_i & DESC_MASK;
      end
      if (wr_hit(req, OFS_FRAME_LENGTH)) begin
         next_frame_cfg = req.wdata & FRAME_CFG_MASK;
      end
   end

   // ======================================================================
   // read mux
   always_comb begin
      next_rdata = ZERO_WORD;
      if (req.rd) begin
         case (req.addr)
            OFS_EVENT_STATUS: next_rdata = status;
            OFS_ENABLE_SET:   next_rdata = mask;
            OFS_ENABLE_CLEAR: next_rdata = mask;
            OFS_SHARED_AREA:  next_rdata = area;
            OFS_PERIODIC_CUR: next_rdata = periodic_cur;
            OFS_CONTROL_HEAD: next_rdata = control_head;
            OFS_CONTROL_CUR:  next_rdata = control_cur;
            OFS_BULK_HEAD:    next_rdata = bulk_head;
            OFS_BULK_CUR:     next_rdata = bulk_cur;
            OFS_DONE_HEAD:    next_rdata = done_head;
            OFS_FRAME_LENGTH: next_rdata = frame_cfg;
            OFS_TIME_LEFT:    next_rdata = {time_toggle, 17'h0, time_left};
            OFS_FRAME_NUMBER: next_rdata = {16'h0000, fnum};
            default:          next_rdata = ZERO_WORD;
         endcase
      end
   end

   // ======================================================================
   // registers
   always_ff @(posedge clk_i or negedge rst_sync) begin
      if (!rst_sync) begin
         status <= ZERO_WORD;
         mask <= ZERO_WORD;
         area <= ZERO_WORD;
         periodic_cur <= ZERO_WORD;
         control_head <= ZERO_WORD;
         control_cur <= ZERO_WORD;
         bulk_head <= ZERO_WORD;
         bulk_cur <= ZERO_WORD;
         done_head <= ZERO_WORD;
         frame_cfg <= FRAME_CFG_RESET;
         time_left <= '0;
         time_toggle <= 1'b0;
         fnum <= '0;
         div_acc <= 8'h00;
         run_d <= 1'b0;
         pkt_cnt <= '0;
         sof <= 1'b0;
         irq <= 1'b0;
         rdata <= ZERO_WORD;
      end else begin
         status <= next_status;
         mask <= next_mask;
         area <= next_area;
         periodic_cur <= next_periodic_cur;
         control_head <= next_control_head;
         control_cur <= next_control_cur;
         bulk_head <= next_bulk_head;
         bulk_cur <= next_bulk_cur;
         done_head <= next_done_head;
         frame_cfg <= next_frame_cfg;
         time_left <= next_time_left;
         time_toggle <= next_time_toggle;
         fnum <= next_fnum;
         div_acc <= next_div_acc;
         run_d <= operational_i;
         pkt_cnt <= next_pkt_cnt;
         sof <= next_sof;
         irq <= next_irq;
         rdata <= next_rdata;
      end
   end

   assign rdata_o = rdata;
   assign irq_o = irq;
   assign frame_start_o = sof;
   assign largest_packet_bits_o = pkt_cnt;
   assign frame_counter_o = fnum;

   // ======================================================================
   // checks
   chk_fatal_zero: assert property (@(posedge clk_i)
      disable iff (!rst_sync) !status[BIT_FATAL] && !mask[BIT_FATAL])
      else $error("fatal error bits not zero");
   chk_owner_set: assert property (@(posedge clk_i)
      disable iff (!rst_sync) owner_change_request_i |=> status[BIT_OWNER])
      else $error("owner change flag not set");
   chk_hub_set: assert property (@(posedge clk_i)
      disable iff (!rst_sync) hub_change_i |=> status[BIT_HUB])
      else $error("hub change flag not set");
   chk_done_set: assert property (@(posedge clk_i)
      disable iff (!rst_sync) done_written_i |=> status[BIT_DONE])
      else $error("done flag not set");
   chk_ovf_set: assert property (@(posedge clk_i)
      disable iff (!rst_sync)
      $changed(fnum[FNUM_TOP]) |-> status[BIT_FRAME_OVF])
      else $error("frame overflow flag not set");
   chk_irq_master: assert property (@(posedge clk_i)
      disable iff (!rst_sync) !mask[BIT_MASTER] |-> !irq)
      else $error("irq without master enable");
   chk_irq_raise: assert property (@(posedge clk_i)
      disable iff (!rst_sync)
      (mask[BIT_MASTER] && |(status & mask & EVENT_MASK)) |-> irq)
      else $error("irq missing");
   chk_fnum_step: assert property (@(posedge clk_i)
      disable iff (!rst_sync) sof |-> fnum == FNUM_W'($past(fnum) + 1'b1))
      else $error("frame counter step wrong");
   chk_area_low: assert property (@(posedge clk_i)
      disable iff (!rst_sync) (area & ~AREA_MASK) == ZERO_WORD)
      else $error("area low bits set");
   chk_reload_val: assert property (@(posedge clk_i)
      disable iff (!rst_sync)
      sof |-> time_left == $past(frame_cfg[FRAME_W-1:0])
             && time_toggle == $past(frame_cfg[TOGGLE_BIT]))
      else $error("reload value wrong");
   chk_sof_flag: assert property (@(posedge clk_i)
      disable iff (!rst_sync) sof |=> status[BIT_SOF])
      else $error("frame start flag not set");
   chk_status_clear: assert property (@(posedge clk_i)
      disable iff (!rst_sync)
      wr_hit(req, OFS_EVENT_STATUS) && req.wdata[BIT_HUB] && !hub_change_i
      |=> !status[BIT_HUB])
      else $error("status flag not cleared");
endmodule
`default_nettype wire

/* File: dv/uhirq_lp_model.sv */
// uhirq_lp_model: list processor and port event source facing the bank.
// assumes the bench calls its tasks from a process that waits on clk_i.
`default_nettype none
module uhirq_lp_model
   import uhirq_pkg::*;
(
   input  wire logic              clk_i,
   output var  uhirq_evt_t        evt_o,
   output var  logic              own_req_o,
   output var  logic [3:0]        hw_we_o,
   output var  logic [DATA_W-1:0] hw_ptr_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      evt_o     = '0;
      own_req_o = 1'b0;
      hw_we_o   = 4'h0;
      hw_ptr_o  = 32'h0000_0000;
   end

   // ==========
   // pointer write: 0 periodic, 1 control, 2 bulk, 3 done head
   task automatic hw_write(input int k, input logic [DATA_W-1:0] p);
      @(posedge clk_i);
      hw_we_o  <= 4'(1 << k);
      hw_ptr_o <= p;
      @(posedge clk_i);
      hw_we_o  <= 4'h0;
      hw_ptr_o <= ~p;
   endtask

   // ==========
   // event pulse: 0 owner, 1 hub, 2 resume, 3 done, 4 overrun
   task automatic pulse(input int k);
      if (k == 3) begin
         hw_write(3, 32'h5A5A_A5A0);
      end
      @(posedge clk_i);
      own_req_o <= (k == 0);
      evt_o     <= '{hub_change: k == 1, resume: k == 2,
                     done_written: k == 3, overrun: k == 4};
      @(posedge clk_i);
      own_req_o <= 1'b0;
      evt_o     <= '0;
   endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// tb: self-checking bench for the event, pointer and frame register bank.
// assumes uhirq_regs and uhirq_lp_model are compiled before it.
`default_nettype none
module tb import uhirq_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;

   logic              clk   = 1'b0;
   logic              rst_n = 1'b0;
   logic              wr    = 1'b0;
   logic              rd    = 1'b0;
   logic              oper  = 1'b0;
   logic [31:0]       addr  = 32'h0000_0000;
   logic [31:0]       wdata = 32'h0000_0000;
   logic [31:0]       rdata;
   logic              irq;
   logic              sof;
   logic [PKT_W-1:0]  pkt;
   logic [FNUM_W-1:0] fnum;
   uhirq_evt_t        evt;
   logic              own_req;
   logic [3:0]        hw_we;
   logic [31:0]       hw_ptr;
   int                miscompares = 0;
   int                n_tests = 0;

   always #5 clk = ~clk;

   uhirq_regs uhirq_regs_i (.clk_i(clk), .rst_n_i(rst_n), .wr_i(wr),
      .rd_i(rd), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
      .owner_change_request_i(own_req), .hub_change_i(evt.hub_change),
      .resume_i(evt.resume), .done_written_i(evt.done_written),
      .overrun_i(evt.overrun), .operational_i(oper),
      .hw_periodic_we_i(hw_we[0]), .hw_control_we_i(hw_we[1]),
      .hw_bulk_we_i(hw_we[2]), .hw_done_we_i(hw_we[3]),
      .hw_pointer_i(hw_ptr), .irq_o(irq), .frame_start_o(sof),
      .largest_packet_bits_o(pkt), .frame_counter_o(fnum));

   uhirq_lp_model uhirq_lp_model_i (.clk_i(clk), .evt_o(evt),
      .own_req_o(own_req), .hw_we_o(hw_we), .hw_ptr_o(hw_ptr));

   // ==========
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus_rd(a, r);
      chk(r, e);
   endtask

   task automatic chk_irq(input logic e);
      repeat (2) @(posedge clk);
      #1 chk({31'h0, irq}, {31'h0, e});
   endtask

   task automatic wait_sof(output int c);
      c = 0;
      do begin
         @(posedge clk);
         #1 c++;
      end while (sof !== 1'b1 && c < 400);
      chk({31'h0, c < 400}, 32'h1);
   endtask

   // ==========
   // scenarios
   task automatic t_reset();
      logic [31:0] a;
      logic [31:0] e;
      for (int i = 0; i < 13; i++) begin
         a = OFS_EVENT_STATUS + 32'(4 * i);
         e = (a == OFS_FRAME_LENGTH) ? FRAME_CFG_RESET : ZERO_WORD;
         chk_rd(a, e);
      end
      bus_wr(32'hB000_7080, 32'hFFFF_FFFF);
      chk_rd(32'hB000_7080, ZERO_WORD);
      bus_wr(OFS_EVENT_STATUS, 32'hFFFF_FFFF);
      chk_rd(OFS_EVENT_STATUS, ZERO_WORD);
   endtask

   task automatic t_regs();
      logic [31:0] r;
      logic [31:0] a;
      logic [31:0] p;
      logic [31:0] hw_a [4];
      hw_a = '{OFS_PERIODIC_CUR, OFS_CONTROL_CUR, OFS_BULK_CUR, OFS_DONE_HEAD};
      bus_wr(OFS_ENABLE_SET, 32'hFFFF_FFFF);
      bus_rd(OFS_ENABLE_SET, r);
      chk(r & 32'h7FFF_FFFF, EVENT_MASK);
      bus_rd(OFS_ENABLE_CLEAR, r);
      chk(r & 32'h7FFF_FFFF, EVENT_MASK);
      bus_wr(OFS_ENABLE_CLEAR, 32'hFFFF_FFFF);
      chk_rd(OFS_ENABLE_SET, ZERO_WORD);
      for (int i = 0; i < 7; i++) begin
         a = OFS_SHARED_AREA + 32'(4 * i);
         bus_wr(a, 32'hFFFF_FFFF);
         chk_rd(a, (i == 0) ? AREA_MASK : DESC_MASK);
      end
      for (int k = 0; k < 4; k++) begin
         p = 32'h89AB_CDEF ^ 32'(k << 8);
         uhirq_lp_model_i.hw_write(k, p);
         chk_rd(hw_a[k], p & DESC_MASK);
      end
   endtask

   task automatic t_events();
      logic [31:0] m;
      int          ebit [5];
      ebit = '{BIT_OWNER, BIT_HUB, BIT_RESUME, BIT_DONE, BIT_OVERRUN};
      for (int k = 0; k < 5; k++) begin
         m = 32'h1 << ebit[k];
         bus_wr(OFS_EVENT_STATUS, 32'hFFFF_FFFF);
         bus_wr(OFS_ENABLE_SET, m | 32'h8000_0000);
         chk_irq(1'b0);
         uhirq_lp_model_i.pulse(k);
         chk_rd(OFS_EVENT_STATUS, m);
         chk_irq(1'b1);
         bus_wr(OFS_ENABLE_SET, ZERO_WORD);
         bus_wr(OFS_ENABLE_CLEAR, ZERO_WORD);
         bus_wr(OFS_EVENT_STATUS, ZERO_WORD);
         chk_irq(1'b1);
         bus_wr(OFS_ENABLE_CLEAR, 32'h8000_0000);
         chk_irq(1'b0);
         bus_wr(OFS_ENABLE_SET, 32'h8000_0000);
         chk_irq(1'b1);
         bus_wr(OFS_ENABLE_CLEAR, m);
         chk_irq(1'b0);
         bus_wr(OFS_EVENT_STATUS, m);
         chk_rd(OFS_EVENT_STATUS, ZERO_WORD);
      end
   endtask

   task automatic t_frame();
      logic [31:0] r;
      logic [15:0] f0;
      int          c;
      bus_wr(OFS_FRAME_LENGTH, 32'h9234_000F);
      chk_rd(OFS_FRAME_LENGTH, 32'h9234_000F);
      bus_wr(OFS_EVENT_STATUS, 32'hFFFF_FFFF);
      @(posedge clk);
      oper <= 1'b1;
      wait_sof(c);
      f0 = fnum;
      chk({17'h0, pkt}, 32'h0000_1234);
      wait_sof(c);
      chk({31'h0, c >= 132 && c <= 135}, 32'h1);
      chk({16'h0, fnum}, {16'h0, f0 + 16'h1});
      bus_rd(OFS_TIME_LEFT, r);
      chk({31'h0, r[31]}, 32'h1);
      bus_rd(OFS_EVENT_STATUS, r);
      chk(r & 32'h4, 32'h4);
      bus_wr(OFS_FRAME_LENGTH, 32'h1234_000F);
      bus_wr(OFS_EVENT_STATUS, 32'hFFFF_FFFF);
      bus_wr(OFS_ENABLE_SET, 32'h8000_0004);
      chk_irq(1'b0);
      wait_sof(c);
      chk_irq(1'b1);
      bus_rd(OFS_TIME_LEFT, r);
      chk({31'h0, r[31]}, 32'h0);
      chk({17'h0, pkt}, 32'h0000_1234);
      @(posedge clk);
      oper <= 1'b0;
   endtask

   task automatic finish_test();
      if (miscompares == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_regs();
      t_events();
      t_frame();
      finish_test();
   end

   initial begin
      #100000;
      miscompares++;
      finish_test();
   end
endmodule
`default_nettype wire
